// ---- pkg/uart_lin_pkg.sv ----
// Constants, types and state layout of the serial engine with line break.
//
// Overview of operation
// - Buffer accepts next byte once shifting starts.
// - Status bit 1 shows buffer still holds byte.
// - Status bit 0 shows frame being shifted.
// - Flags pass 10, 11, 01 while loading.
// - Falling edge, half bit later low means start.
// - Stop bit loads buffer unless overrun; pulses done, or error line on an error with merge low.
// - Parity error keeps frame running to stop.
// - Receiver checks only one stop bit.
// - Parity, framing and overrun errors are flagged.
// - Reading error status clears it.
// - Merge bit low routes errors to error line.
// - Receive input changes when two samples agree.
// - Break trigger drives 13 to 20 low bits.
// - After break the transmitter idles, or loads a byte written during the break.
// - Break receive enable arms break detection.
// - Long break pulses done, clears flags, buffer kept.
// - No error flags during break reception.
// - Short break is ignored, detection stays armed.
// - Mode bits 7, 6, 5: power, transmit, receive.
// - Frame: start, 7 or 8 bits, parity, stops.
// - Transmit done pulses after final stop bit.
package uart_lin_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_TX_STATUS = 3'h1;
    localparam logic [2:0] ADDR_RX_ERROR = 3'h2;
    localparam logic [2:0] ADDR_BREAK_CTRL = 3'h3;
    localparam logic [2:0] ADDR_BAUD_DIV = 3'h4;
    localparam logic [2:0] ADDR_DATA = 3'h5;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int MODE_POWER = 7;
    localparam int MODE_TX_EN = 6;
    localparam int MODE_RX_EN = 5;
    localparam int MODE_PAR_HI = 4;
    localparam int MODE_PAR_LO = 3;
    localparam int MODE_CHAR8 = 2;
    localparam int MODE_STOP2 = 1;
    localparam int MODE_MERGE = 0;
    localparam int BRK_RX_FLAG = 7;
    localparam int BRK_RX_EN = 6;
    localparam int BRK_TX_TRIG = 5;
    localparam int BRK_LEN_HI = 4;
    localparam int BRK_LEN_LO = 2;
    localparam int BRK_DIR_MSB = 1;
    localparam int BRK_TX_INV = 0;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [4:0] BRK_TX_BASE = 5'h0d;
    localparam logic [4:0] BRK_RX_MIN_BITS = 5'h0b;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] BAUD_DIV_RESET = 8'hff;
    localparam logic [7:0] RX_BUF_RESET = 8'hff;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOAD = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] div;
        logic [2:0] brk_len;
        logic dir_msb;
        logic tx_inv;
        logic brk_rx_en;
        logic brk_rx_flag;
        logic brk_tx_trig;
        logic [7:0] tx_buf;
        logic tx_full;
        logic tx_busy;
        logic tx_brk;
        tx_state_t tx_state;
        logic [19:0] tx_sh;
        logic [4:0] tx_left;
        logic [8:0] tx_cnt;
        logic [2:0] sync;
        logic rx_filt;
        logic rx_prev;
        rx_state_t rx_state;
        logic [8:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [7:0] rx_sh;
        logic rx_par;
        logic [4:0] rx_low;
        logic [7:0] rx_buf;
        logic rx_full;
        logic ove;
        logic fe;
        logic pe;
        logic [7:0] rd_data;
        logic tx_pin;
        logic tx_irq;
        logic rx_irq;
        logic rxe_irq;
    } engine_t;

    localparam engine_t ENGINE_RESET = '{
        mode: MODE_RESET, div: BAUD_DIV_RESET, brk_len: 3'h0,
        dir_msb: 1'b0, tx_inv: 1'b0, brk_rx_en: 1'b0,
        brk_rx_flag: 1'b0, brk_tx_trig: 1'b0, tx_buf: 8'h00,
        tx_full: 1'b0, tx_busy: 1'b0, tx_brk: 1'b0,
        tx_state: TX_IDLE, tx_sh: 20'hfffff, tx_left: 5'h00,
        tx_cnt: 9'h000, sync: 3'h7, rx_filt: 1'b1, rx_prev: 1'b1,
        rx_state: RX_IDLE, rx_cnt: 9'h000, rx_bits: 4'h0,
        rx_sh: 8'h00, rx_par: 1'b0, rx_low: 5'h00,
        rx_buf: RX_BUF_RESET, rx_full: 1'b0, ove: 1'b0, fe: 1'b0,
        pe: 1'b0, rd_data: 8'h00, tx_pin: 1'b1, tx_irq: 1'b0,
        rx_irq: 1'b0, rxe_irq: 1'b0
    };

endpackage

// ---- verilog/uart_lin_engine.sv ----
// Serial transmit and receive engine with line break support.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module uart_lin_engine
    import uart_lin_pkg::*;
#(
    parameter int BRK_RX_MIN = 11
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    input wire logic i_rx_pin,
    output logic o_tx_pin,
    output logic o_tx_done_irq,
    output logic o_rx_done_irq,
    output logic o_rx_error_irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (BRK_RX_MIN < 2 || BRK_RX_MIN > 31) begin : g_bad_min
        $error("BRK_RX_MIN must lie between 2 and 31.");
    end

    localparam logic [4:0] BRK_MIN = 5'(BRK_RX_MIN);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] reverse_bits(input logic [7:0] v,
                                                input logic char8);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return char8 ? r : {1'b0, r[7:1]};
    endfunction

    function automatic logic [4:0] frame_len(input logic [7:0] m);
        logic [4:0] n;
        n = m[MODE_CHAR8] ? 5'h09 : 5'h08;
        if (m[MODE_PAR_HI:MODE_PAR_LO] != PAR_NONE) begin
            n = n + 5'h01;
        end
        return m[MODE_STOP2] ? n + 5'h02 : n + 5'h01;
    endfunction

    // Bit 0 leaves the pin first; unused upper positions stay high.
    function automatic logic [19:0] build_frame(input logic [7:0] data,
                                                input logic [7:0] m,
                                                input logic msb);
        logic [7:0] d;
        logic [19:0] f;
        logic p;
        logic [4:0] pos;
        d = msb ? reverse_bits(data, m[MODE_CHAR8]) : data;
        if (!m[MODE_CHAR8]) begin
            d[7] = 1'b0;
        end
        p = ^d;
        f = 20'hfffff;
        f[0] = 1'b0;
        pos = m[MODE_CHAR8] ? 5'h09 : 5'h08;
        for (int i = 0; i < 8; i++) begin
            if (5'(i + 1) < pos) begin
                f[i + 1] = d[i];
            end
        end
        case (m[MODE_PAR_HI:MODE_PAR_LO])
            PAR_ZERO: f[pos] = 1'b0;
            PAR_ODD: f[pos] = ~p;
            PAR_EVEN: f[pos] = p;
            default: f[pos] = 1'b1;
        endcase
        return f;
    endfunction

    function automatic logic bit_done(input logic [8:0] cnt,
                                      input logic [7:0] div);
        return cnt == ({div, 1'b0} - 9'h001);
    endfunction

    engine_t s_q;
    engine_t s_d;

    always_comb begin
        logic [7:0] data;
        logic [3:0] nd;
        logic par_en;
        logic err;
        engine_t keep;
        data = 8'h00;
        nd = 4'h0;
        par_en = 1'b0;
        err = 1'b0;
        keep = ENGINE_RESET;
        s_d = s_q;
        s_d.rd_data = 8'h00;
        s_d.tx_irq = 1'b0;
        s_d.rx_irq = 1'b0;
        s_d.rxe_irq = 1'b0;

        // --------------------------------------------------------
        // Input filter
        // --------------------------------------------------------
        // The first stage only feeds the second, keeping metastable
        // values out of the comparison.
        s_d.sync = {s_q.sync[1:0], i_rx_pin};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.rx_filt = s_q.sync[2];
        end
        s_d.rx_prev = s_q.rx_filt;

        // --------------------------------------------------------
        // Register reads
        // --------------------------------------------------------
        if (i_rd) begin
            case (i_addr)
                ADDR_MODE: s_d.rd_data = s_q.mode;
                ADDR_TX_STATUS: s_d.rd_data =
                    {6'h00, s_q.tx_full, s_q.tx_busy};
                ADDR_RX_ERROR: begin
                    s_d.rd_data = {5'h00, s_q.pe, s_q.fe, s_q.ove};
                    s_d.pe = 1'b0;
                    s_d.fe = 1'b0;
                    s_d.ove = 1'b0;
                end
                ADDR_BREAK_CTRL: s_d.rd_data = {s_q.brk_rx_flag,
                    s_q.brk_rx_en, s_q.brk_tx_trig, s_q.brk_len,
                    s_q.dir_msb, s_q.tx_inv};
                ADDR_BAUD_DIV: s_d.rd_data = s_q.div;
                ADDR_DATA: begin
                    s_d.rd_data = s_q.rx_buf;
                    s_d.rx_full = 1'b0;
                end
                default: s_d.rd_data = 8'h00;
            endcase
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (i_wr) begin
            case (i_addr)
                ADDR_MODE: s_d.mode = i_wr_data;
                ADDR_BREAK_CTRL: begin
                    s_d.brk_len = i_wr_data[BRK_LEN_HI:BRK_LEN_LO];
                    s_d.dir_msb = i_wr_data[BRK_DIR_MSB];
                    s_d.tx_inv = i_wr_data[BRK_TX_INV];
                    s_d.brk_rx_en = i_wr_data[BRK_RX_EN];
                    s_d.brk_rx_flag = i_wr_data[BRK_RX_EN];
                    if (i_wr_data[BRK_TX_TRIG] && s_q.mode[MODE_TX_EN]) begin
                        s_d.brk_tx_trig = 1'b1;
                    end
                end
                ADDR_BAUD_DIV: s_d.div = i_wr_data;
                ADDR_DATA: begin
                    if (s_q.mode[MODE_TX_EN]) begin
                        s_d.tx_buf = i_wr_data;
                        s_d.tx_full = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // Transmitter
        // --------------------------------------------------------
        case (s_q.tx_state)
            TX_IDLE: begin
                if (s_q.tx_full) begin
                    s_d.tx_busy = 1'b1;
                    s_d.tx_state = TX_LOAD;
                end else if (s_q.brk_tx_trig) begin
                    s_d.tx_sh = 20'h00000;
                    s_d.tx_left = BRK_TX_BASE + {2'h0, s_q.brk_len};
                    s_d.tx_brk = 1'b1;
                    s_d.tx_busy = 1'b1;
                    s_d.tx_cnt = 9'h000;
                    s_d.tx_state = TX_SHIFT;
                end
            end
            TX_LOAD: begin
                s_d.tx_sh = build_frame(s_q.tx_buf, s_q.mode,
                    s_q.dir_msb);
                s_d.tx_left = frame_len(s_q.mode);
                s_d.tx_full = s_d.tx_full & i_wr &
                    (i_addr == ADDR_DATA);
                s_d.tx_brk = 1'b0;
                s_d.tx_cnt = 9'h000;
                s_d.tx_state = TX_SHIFT;
            end
            TX_SHIFT: begin
                s_d.tx_cnt = s_q.tx_cnt + 9'h001;
                if (bit_done(s_q.tx_cnt, s_q.div)) begin
                    s_d.tx_cnt = 9'h000;
                    s_d.tx_sh = {1'b1, s_q.tx_sh[19:1]};
                    s_d.tx_left = s_q.tx_left - 5'h01;
                    if (s_q.tx_left == 5'h01) begin
                        s_d.tx_irq = 1'b1;
                        if (s_q.tx_brk) begin
                            s_d.brk_tx_trig = 1'b0;
                        end
                        // Returning to idle, or loading a byte written meanwhile, resumes normal sending.
                        if (s_d.tx_full) begin
                            s_d.tx_state = TX_LOAD;
                        end else begin
                            s_d.tx_busy = 1'b0;
                            s_d.tx_state = TX_IDLE;
                        end
                    end
                end
            end
            default: s_d.tx_state = TX_IDLE;
        endcase
        s_d.tx_pin = (s_d.tx_state == TX_SHIFT ? s_d.tx_sh[0] : 1'b1)
            ^ s_q.tx_inv;
        if (!s_q.mode[MODE_TX_EN]) begin
            s_d.tx_state = TX_IDLE;
            s_d.tx_full = 1'b0;
            s_d.tx_busy = 1'b0;
            s_d.brk_tx_trig = 1'b0;
            s_d.tx_pin = 1'b1;
        end

        // --------------------------------------------------------
        // Receiver
        // --------------------------------------------------------
        nd = s_q.mode[MODE_CHAR8] ? 4'h8 : 4'h7;
        par_en = s_q.mode[MODE_PAR_HI:MODE_PAR_LO] != PAR_NONE;
        case (s_q.rx_state)
            RX_IDLE: begin
                if (s_q.rx_prev && !s_q.rx_filt) begin
                    s_d.rx_cnt = 9'h000;
                    s_d.rx_state = RX_START;
                end
            end
            RX_START: begin
                s_d.rx_cnt = s_q.rx_cnt + 9'h001;
                if (s_q.rx_cnt == {1'b0, s_q.div} - 9'h001) begin
                    s_d.rx_cnt = 9'h000;
                    s_d.rx_bits = 4'h0;
                    s_d.rx_sh = 8'h00;
                    s_d.rx_par = 1'b0;
                    s_d.rx_low = 5'h01;
                    s_d.rx_state = s_q.rx_filt ? RX_IDLE : RX_BITS;
                end
            end
            RX_BITS: begin
                s_d.rx_cnt = s_q.rx_cnt + 9'h001;
                if (bit_done(s_q.rx_cnt, s_q.div)) begin
                    s_d.rx_cnt = 9'h000;
                    s_d.rx_bits = s_q.rx_bits + 4'h1;
                    if (s_q.brk_rx_en) begin
                        // Error flags are left alone here.
                        if (!s_q.rx_filt) begin
                            if (s_q.rx_low != 5'h1f) begin
                                s_d.rx_low = s_q.rx_low + 5'h01;
                            end
                        end else begin
                            s_d.rx_state = RX_IDLE;
                            if (s_q.rx_low >= BRK_MIN) begin
                                s_d.rx_irq = 1'b1;
                                s_d.brk_rx_en = 1'b0;
                                s_d.brk_rx_flag = 1'b0;
                            end
                        end
                    end else if (s_q.rx_bits < nd) begin
                        s_d.rx_par = s_q.rx_par ^ s_q.rx_filt;
                        s_d.rx_sh = s_q.dir_msb ?
                            {s_q.rx_sh[6:0], s_q.rx_filt} :
                            {s_q.rx_filt, s_q.rx_sh[7:1]};
                    end else if (par_en && s_q.rx_bits == nd) begin
                        // A bad parity is only recorded; the frame runs on.
                        case (s_q.mode[MODE_PAR_HI:MODE_PAR_LO])
                            PAR_ODD: s_d.rx_par =
                                ~(s_q.rx_par ^ s_q.rx_filt);
                            PAR_EVEN: s_d.rx_par = s_q.rx_par ^ s_q.rx_filt;
                            default: s_d.rx_par = 1'b0;
                        endcase
                    end else begin
                        // Only the first stop bit is checked.
                        s_d.rx_state = RX_IDLE;
                        data = s_q.rx_sh;
                        if (!s_q.dir_msb && !s_q.mode[MODE_CHAR8]) begin
                            data = {1'b0, s_q.rx_sh[7:1]};
                        end
                        if (!s_q.mode[MODE_CHAR8]) begin
                            data[7] = 1'b0;
                        end
                        err = (par_en & s_q.rx_par) | ~s_q.rx_filt |
                            s_q.rx_full;
                        if (par_en && s_q.rx_par) begin
                            s_d.pe = 1'b1;
                        end
                        if (!s_q.rx_filt) begin
                            s_d.fe = 1'b1;
                        end
                        if (s_q.rx_full) begin
                            s_d.ove = 1'b1;
                        end else begin
                            s_d.rx_buf = data;
                            s_d.rx_full = 1'b1;
                        end
                        if (err && !s_q.mode[MODE_MERGE]) begin
                            s_d.rxe_irq = 1'b1;
                        end else begin
                            s_d.rx_irq = 1'b1;
                        end
                    end
                end
            end
            default: s_d.rx_state = RX_IDLE;
        endcase
        if (!s_q.mode[MODE_RX_EN]) begin
            s_d.rx_state = RX_IDLE;
            s_d.rx_irq = 1'b0;
            s_d.rxe_irq = 1'b0;
        end

        // --------------------------------------------------------
        // Power
        // --------------------------------------------------------
        // Clearing power drops all engine state except the sync stages, mode, divider, break length, order and inversion, which are kept.
        if (!s_q.mode[MODE_POWER]) begin
            keep = s_d;
            s_d = ENGINE_RESET;
            s_d.mode = keep.mode;
            s_d.div = keep.div;
            s_d.brk_len = keep.brk_len;
            s_d.dir_msb = keep.dir_msb;
            s_d.tx_inv = keep.tx_inv;
            s_d.sync = keep.sync;
            if (i_rd) begin
                case (i_addr)
                    ADDR_MODE: s_d.rd_data = s_q.mode;
                    ADDR_BAUD_DIV: s_d.rd_data = s_q.div;
                    ADDR_DATA: s_d.rd_data = RX_BUF_RESET;
                    default: s_d.rd_data = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= ENGINE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rd_data = s_q.rd_data;
    assign o_tx_pin = s_q.tx_pin;
    assign o_tx_done_irq = s_q.tx_irq;
    assign o_rx_done_irq = s_q.rx_irq;
    assign o_rx_error_irq = s_q.rxe_irq;

endmodule // uart_lin_engine
`default_nettype wire

// ---- verif/uart_lin_sva.sv ----
// Port-level assertions for the serial engine with line break.
`timescale 1ns/1ps
`default_nettype none
module uart_lin_sva
    import uart_lin_pkg::*;
#(
    parameter int BRK_RX_MIN = 11
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rd_data,
    input wire logic o_tx_pin,
    input wire logic o_tx_done_irq,
    input wire logic o_rx_done_irq,
    input wire logic o_rx_error_irq
);
    // ----
    // Mode shadow and properties
    // ----
    logic [7:0] mode_q;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mode_q <= MODE_RESET;
        end else if (i_wr && i_addr == ADDR_MODE) begin
            mode_q <= i_wr_data;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    property p_clr;
        i_rd && i_addr == ADDR_RX_ERROR ##1 i_rd && i_addr == ADDR_RX_ERROR
        && !o_rx_done_irq && !o_rx_error_irq
        |=> o_rd_data == 8'h00 || o_rx_done_irq || o_rx_error_irq;
    endproperty
    property p_sta;
        i_rd && i_addr == ADDR_TX_STATUS |=> o_rd_data[7:2] == 6'h00;
    endproperty
    property p_merge;
        $past(mode_q[MODE_MERGE], 2) && $past(mode_q[MODE_MERGE])
        |-> !o_rx_error_irq;
    endproperty
    property p_route;
        o_rx_error_irq |-> !$past(mode_q[MODE_MERGE]) && !o_rx_done_irq;
    endproperty
    property p_txp;
        o_tx_done_irq |=> !o_tx_done_irq;
    endproperty
    property p_rxp;
        o_rx_done_irq |=> !o_rx_done_irq;
    endproperty
    property p_pwr;
        i_wr && i_addr == ADDR_MODE && i_wr_data[7:5] == 3'h0
        |-> ##2 (o_tx_pin && !o_tx_done_irq && !o_rx_done_irq) [*3];
    endproperty
    property p_rdz;
        !$past(i_rd) |-> o_rd_data == 8'h00;
    endproperty
    a_clr: assert property (p_clr)
        else $error("Status kept.");
    a_sta: assert property (p_sta)
        else $error("Status bits set.");
    a_merge: assert property (p_merge)
        else $error("Error line used.");
    a_route: assert property (p_route)
        else $error("Bad routing.");
    a_txp: assert property (p_txp)
        else $error("Long tx pulse.");
    a_rxp: assert property (p_rxp)
        else $error("Long rx pulse.");
    a_pwr: assert property (p_pwr)
        else $error("Active when off.");
    a_rdz: assert property (p_rdz)
        else $error("Stray data.");
    c_txd: cover property (o_tx_done_irq);
    c_err: cover property (o_rx_error_irq);
    c_brk: cover property (i_wr && i_addr == ADDR_BREAK_CTRL
        && i_wr_data[BRK_RX_EN]);
endmodule // uart_lin_sva
bind uart_lin_engine uart_lin_sva #(.BRK_RX_MIN(BRK_RX_MIN)) sva_i (
    .i_clock, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .o_tx_pin, .o_tx_done_irq, .o_rx_done_irq, .o_rx_error_irq
);
`default_nettype wire

// ---- verif/remote_node.sv ----
// Behavioural remote serial node driving the receive line.
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
    parameter int BIT = 8
) (
    input wire logic i_clock,
    output var logic o_line
);
    // ----
    // Line driver
    // ----
    initial o_line = 1'b1;
    task automatic level(input logic v, input int n);
        o_line <= v;
        repeat (n) @(posedge i_clock);
    endtask
    task automatic send(input logic [7:0] d, input logic pv,
        input logic stp);
        level(1'b0, BIT);
        for (int i = 0; i < 8; i++) level(d[i], BIT);
        level(pv, BIT);
        level(stp, BIT);
        if (!stp) level(1'b1, 1);
    endtask
    task automatic low(input int n);
        level(1'b0, n);
        level(1'b1, 1);
    endtask
endmodule // remote_node
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the serial engine against a remote node.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uart_lin_pkg::*;
    // ----
    // Bench
    // ----
    localparam int BIT = 8;
    logic i_clock, i_rst_n, i_wr, i_rd, rd_d1, m;
    logic [2:0] i_addr;
    logic [7:0] i_wr_data, o_rd_data, b, b2, got;
    logic [7:0] rdq[$], seen[$];
    logic o_tx_pin, o_tx_done_irq, o_rx_done_irq, o_rx_error_irq;
    wire rx_line;
    int failures, comparisons, cyc, ntx, nrx, nerr, lowrun, k, d0, e0;
    uart_lin_engine #(.BRK_RX_MIN(11)) DUT (
        .i_clock, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
        .i_rx_pin(rx_line), .o_tx_pin, .o_tx_done_irq, .o_rx_done_irq,
        .o_rx_error_irq
    );
    remote_node #(.BIT(BIT)) peer (.i_clock(i_clock), .o_line(rx_line));
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (rd_d1) rdq.push_back(o_rd_data);
        rd_d1 <= i_rd;
        cyc <= cyc + 1;
        ntx <= ntx + int'(o_tx_done_irq);
        nrx <= nrx + int'(o_rx_done_irq);
        nerr <= nerr + int'(o_rx_error_irq);
        lowrun <= lowrun + int'(!o_tx_pin);
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] seen_v, input logic [7:0] exp);
        comparisons++;
        if (seen_v !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, seen_v, exp);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [2:0] a,
        input logic [7:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clock);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask
    task automatic rds(input logic [2:0] a, input int n);
        repeat (n) bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 3'h0, 8'h00);
        @(posedge i_clock);
    endtask
    task automatic rd1(input logic [2:0] a, input logic [7:0] exp);
        rds(a, 1);
        check(rdq.pop_front(), exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    function automatic logic [7:0] err_code(input int i);
        return {5'h00, i[0], i[1], 1'b0};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial forever begin
        @(negedge o_tx_pin);
        settle(BIT / 2);
        for (int i = 0; i < 8; i++) begin
            settle(BIT);
            got[i] = o_tx_pin;
        end
        settle(BIT);
        if (o_tx_pin === 1'b1) seen.push_back(got);
    end
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wr_data = 8'h00;
        rd_d1 = 1'b0;
        void'($urandom(32'ha6b5));
        settle(10);
        i_rst_n <= 1'b1;
        settle(1);
        rd1(ADDR_MODE, MODE_RESET);
        rd1(ADDR_TX_STATUS, 8'h00);
        rd1(3'h7, 8'h00);
        $display("test reset done");
        wr(ADDR_BAUD_DIV, 8'(BIT / 2));
        wr(ADDR_MODE, 8'h84);
        wr(ADDR_MODE, 8'he4);
        wr(ADDR_BREAK_CTRL, 8'h40);
        rd1(ADDR_BREAK_CTRL, 8'hc0);
        d0 = nrx;
        peer.low(10 * BIT);
        settle(3 * BIT);
        check(8'(nrx - d0), 8'h00);
        rd1(ADDR_BREAK_CTRL, 8'hc0);
        peer.low(11 * BIT);
        settle(3 * BIT);
        check(8'(nrx - d0), 8'h01);
        check(8'(nerr), 8'h00);
        rd1(ADDR_BREAK_CTRL, 8'h00);
        rd1(ADDR_RX_ERROR, 8'h00);
        rd1(ADDR_DATA, RX_BUF_RESET);
        $display("test break receive done");
        b = 8'($urandom);
        b2 = 8'($urandom);
        d0 = cyc;
        bus(1'b1, 1'b0, ADDR_DATA, b);
        rds(ADDR_TX_STATUS, 3);
        check(rdq.pop_front(), 8'h02);
        check(rdq.pop_front(), 8'h03);
        check(rdq.pop_front(), 8'h01);
        bus(1'b1, 1'b0, ADDR_DATA, b2);
        rd1(ADDR_TX_STATUS, 8'h03);
        for (k = 0; k < 400 && ntx < 2; k++) settle(1);
        check(8'(ntx), 8'h02);
        check(8'(cyc - d0 <= 20 * BIT + 12), 8'h01);
        rd1(ADDR_TX_STATUS, 8'h00);
        check(seen.pop_front(), b);
        check(seen.pop_front(), b2);
        k = $urandom_range(7, 0);
        d0 = lowrun;
        wr(ADDR_BREAK_CTRL, {3'b001, 3'(k), 2'b00});
        for (e0 = 0; e0 < 400 && ntx < 3; e0++) settle(1);
        check(8'(lowrun - d0), 8'((int'(BRK_TX_BASE) + k) * BIT));
        rd1(ADDR_BREAK_CTRL, {3'b000, 3'(k), 2'b00});
        d0 = lowrun;
        settle(4 * BIT);
        check(8'(lowrun - d0 + ntx), 8'h03);
        $display("test transmit done");
        for (int i = 0; i < 4; i++) begin
            m = (i == 2);
            b = 8'($urandom);
            wr(ADDR_MODE, {7'h7e, m});
            d0 = nrx;
            e0 = nerr;
            peer.send(b, ^b ^ i[0], !i[1]);
            settle(3 * BIT);
            check(8'(nrx - d0), 8'(i == 0 || m));
            check(8'(nerr - e0), 8'(i != 0 && !m));
            rds(ADDR_RX_ERROR, 2);
            check(rdq.pop_front(), err_code(i));
            check(rdq.pop_front(), 8'h00);
            rd1(ADDR_DATA, b);
        end
        d0 = nrx;
        e0 = nerr;
        peer.low(1);
        settle(3 * BIT);
        check(8'(nrx + nerr - d0 - e0), 8'h00);
        wr(ADDR_MODE, 8'hfe);
        peer.send(b, ^b, 1'b1);
        peer.send(~b, ^b, 1'b1);
        settle(3 * BIT);
        check(8'(nrx - d0), 8'h01);
        check(8'(nerr - e0), 8'h01);
        rd1(ADDR_RX_ERROR, 8'h01);
        rd1(ADDR_DATA, b);
        wr(ADDR_MODE, 8'h05);
        settle(4);
        check(8'(o_tx_pin), 8'h01);
        $display("test receive done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
